// ### idm_pkg.sv
// Shared constants and types for the isolated driver mode control
package idm_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS  = 8;
	localparam int BURST_NS       = 25000;
	localparam int STARTUP_BURSTS = 4;
	localparam int SPACING_NS     = 400;
	localparam int BURST_CYC      = BURST_NS / CLK_PERIOD_NS;
	localparam int STARTUP_CYC    = STARTUP_BURSTS * BURST_CYC;
	localparam int SPACING_CYC    = SPACING_NS / CLK_PERIOD_NS;
	localparam int RECOVERY_CYC   = 1000;
	localparam int PRIM_LOSS_CYC  = 100;

	// ----------------------------------------
	// Register map (APB byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam int CTRL_LATCH_BIT      = 0;
	localparam logic CTRL_LATCH_RST    = 1'h0;

	// Back-channel slot, one-hot
	typedef enum logic [2:0]
	{
		SLOT_FAULT = 3'h1,
		SLOT_ALARM = 3'h2,
		SLOT_POWER = 3'h4
	} idm_slot_t;

	// Status word as read by software
	typedef struct packed
	{
		logic power_ok;
		logic alarm_ok;
		logic fault_ok;
		logic live;
		logic fault_hold;
		logic gate;
	} idm_status_t;
endpackage

// ### idm_mode_ctrl.sv
// Mode, fault and status back-channel control for an isolated switch driver
//
// Operation
// - Primary and secondary down: gate low, keep-off on, power-ok floating.
// - Transfer enable low with primary up: gate low, power-ok driven low.
// - All supplies valid and enable high: gate follows command, power-ok high.
// - No comparator tripped: both pins released, gate follows command.
// - Non-latching fault: gate low until the recovery timer elapses.
// - Latching fault: gate low until command low-then-high and timer elapsed.
// - Alarm alone is reported but never touches the gate.
// - Both comparators tripped: both pins low, fault behaviour on gate.
// - Status sent one at a time: fault, alarm, power-ok, 400 ns apart.
// - After primary power-up, indicators held low for four 25 us bursts.
`timescale 1ns/1ps
module idm_mode_ctrl
	import idm_pkg::*;
#(
	parameter int STARTUP_LEN  = STARTUP_CYC,
	parameter int RECOVERY_LEN = RECOVERY_CYC,
	parameter int PRIM_LOSS_LEN = PRIM_LOSS_CYC
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic        primary_supply_ok_i,
	input  wire logic        primary_energy_ok_i,
	input  wire logic        secondary_high_rail_ok_i,
	input  wire logic        secondary_mid_rail_ok_i,
	input  wire logic        xfer_enable_i,
	input  wire logic        switch_cmd_i,
	input  wire logic        fault_compare_in_i,
	input  wire logic        alarm_compare_in_i,
	output logic             gate_drive_out_o,
	output logic             keep_off_o,
	output logic             power_ok_indicator_o,
	output logic             power_ok_indicator_oe_n_o,
	output logic             fault_indicator_n_o,
	output logic             fault_indicator_n_oe_n_o,
	output logic             alarm_indicator_n_o,
	output logic             alarm_indicator_n_oe_n_o
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic        latch_mode;
	logic        prim_seen;
	logic [15:0] loss_cnt;
	logic        fault_hold;
	logic        en_low_seen;
	logic [15:0] rec_cnt;
	logic [15:0] start_cnt;
	logic        live;
	logic [15:0] gap_cnt;
	idm_slot_t   slot;
	logic        fault_ind;
	logic        alarm_ind;
	logic        power_ind;
	logic        power_hiz;
	logic        gate;
	idm_status_t status;
	logic        sec_ok;
	logic        fault_now;
	logic        tick;
	logic        rec_done;
	logic        next_gate;
	logic        fault_val;

	assign sec_ok    = secondary_high_rail_ok_i & secondary_mid_rail_ok_i;
	assign fault_now = fault_compare_in_i & sec_ok;
	assign tick      = (gap_cnt == 16'(SPACING_CYC - 1));
	assign rec_done  = (rec_cnt >= 16'(RECOVERY_LEN - 1));
	// Latched variant keeps the fault pin low as long as the hold stands
	assign fault_val = ~(fault_compare_in_i | (latch_mode & fault_hold));

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Zero wait states; read data is caught in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & (paddr != ADDR_CTRL) & (paddr != ADDR_STATUS);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			latch_mode <= CTRL_LATCH_RST;
		else if (psel && penable && pwrite && paddr == ADDR_CTRL)
			latch_mode <= pwdata[CTRL_LATCH_BIT];
	end

	assign status = '{power_ok: power_ind, alarm_ok: alarm_ind, fault_ok: fault_ind,
		live: live, fault_hold: fault_hold, gate: gate};

	// Unmapped reads return zero
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
		begin
			if (paddr == ADDR_CTRL)
				prdata <= {31'h0, latch_mode};
			else if (paddr == ADDR_STATUS)
				prdata <= {26'h0, status};
			else
				prdata <= 32'h0;
		end
	end

	// ----------------------------------------
	// Primary loss as seen by the secondary
	// ----------------------------------------
	// loss reaches the driver at once, or by timeout when energy is short
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prim_seen <= 1'b0;
			loss_cnt  <= 16'h0;
		end
		else if (primary_supply_ok_i)
		begin
			prim_seen <= 1'b1;
			loss_cnt  <= 16'h0;
		end
		else if (primary_energy_ok_i || loss_cnt == 16'(PRIM_LOSS_LEN - 1))
			prim_seen <= 1'b0;
		else if (prim_seen)
			loss_cnt <= loss_cnt + 16'h1;
	end

	// ----------------------------------------
	// Fault hold and recovery timer
	// ----------------------------------------
	// non-latching release after the recovery time, timer restarts on refault
	// latching release also needs the command taken low then high
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fault_hold  <= 1'b0;
			en_low_seen <= 1'b0;
			rec_cnt     <= 16'h0;
		end
		else if (fault_now)
		begin
			fault_hold  <= 1'b1;
			en_low_seen <= 1'b0;
			rec_cnt     <= 16'h0;
		end
		else if (fault_hold)
		begin
			if (!switch_cmd_i)
				en_low_seen <= 1'b1;
			if (!rec_done)
				rec_cnt <= rec_cnt + 16'h1;
			if (rec_done && (!latch_mode || (en_low_seen && switch_cmd_i)))
				fault_hold <= 1'b0;
		end
	end

	// ----------------------------------------
	// Gate drive
	// ----------------------------------------
	// gate only with every supply up and transfer enabled
	// the alarm comparator has no path into the gate
	// fault comparator blocks the gate at the first edge after it trips, ahead of the hold
	assign next_gate = prim_seen & xfer_enable_i & sec_ok & switch_cmd_i
		& ~fault_now & ~fault_hold;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			gate       <= 1'b0;
			keep_off_o <= 1'b1;
		end
		else
		begin
			gate       <= next_gate;
			keep_off_o <= ~next_gate;
		end
	end

	assign gate_drive_out_o = gate;

	// ----------------------------------------
	// Start-up quiet period
	// ----------------------------------------
	// four burst periods pass before status goes live
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			start_cnt <= 16'h0;
			live      <= 1'b0;
		end
		else if (!primary_supply_ok_i)
		begin
			start_cnt <= 16'h0;
			live      <= 1'b0;
		end
		else if (!live)
		begin
			start_cnt <= start_cnt + 16'h1;
			live      <= (start_cnt == 16'(STARTUP_LEN - 1));
		end
	end

	// ----------------------------------------
	// Back-channel sequencer
	// ----------------------------------------
	// one slot every spacing period, fixed rotation
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			gap_cnt <= 16'h0;
			slot    <= SLOT_FAULT;
		end
		else if (tick)
		begin
			gap_cnt <= 16'h0;
			unique case (slot)
				SLOT_FAULT: slot <= SLOT_ALARM;
				SLOT_ALARM: slot <= SLOT_POWER;
				SLOT_POWER: slot <= SLOT_FAULT;
				default:    slot <= SLOT_FAULT;
			endcase
		end
		else
			gap_cnt <= gap_cnt + 16'h1;
	end

	// Indicators: 1 means released, 0 means pulled low
	// transfer enable low pulls both comparator pins low at once
	// live values taken only in their own slot, hence the lag
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fault_ind <= 1'b0;
			alarm_ind <= 1'b0;
			power_ind <= 1'b0;
		end
		else if (!primary_supply_ok_i || !xfer_enable_i || !live)
		begin
			fault_ind <= 1'b0;
			alarm_ind <= 1'b0;
			power_ind <= 1'b0;
		end
		else if (tick)
		begin
			if (slot == SLOT_FAULT)
				fault_ind <= fault_val;
			if (slot == SLOT_ALARM)
				alarm_ind <= ~alarm_compare_in_i;
			if (slot == SLOT_POWER)
				power_ind <= sec_ok;
		end
	end

	// power-ok floats only in reset or with both sides down
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			power_hiz <= 1'b1;
		else
			power_hiz <= ~primary_supply_ok_i & ~sec_ok;
	end

	// Fault and alarm open drain: data stays low, enable low pulls the pin; power-ok drives its value
	assign fault_indicator_n_o       = 1'b0;
	assign fault_indicator_n_oe_n_o  = fault_ind;
	assign alarm_indicator_n_o       = 1'b0;
	assign alarm_indicator_n_oe_n_o  = alarm_ind;
	assign power_ok_indicator_o      = power_ind;
	assign power_ok_indicator_oe_n_o = power_hiz;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_down_pin_float: assert property (
		!primary_supply_ok_i && !sec_ok |=> power_ok_indicator_oe_n_o && !gate_drive_out_o)
		else $error("power-ok not floating or gate high while down");
	a_ce_low_off: assert property (
		primary_supply_ok_i && !xfer_enable_i |=> !gate_drive_out_o && !power_ok_indicator_o)
		else $error("gate or power-ok high with transfer disabled");
	a_gate_follows: assert property (
		prim_seen && xfer_enable_i && sec_ok && switch_cmd_i && !fault_compare_in_i && !fault_hold
		|=> gate_drive_out_o && !keep_off_o)
		else $error("gate did not follow command");
	a_cmd_low_off: assert property (
		!switch_cmd_i |=> !gate_drive_out_o && keep_off_o)
		else $error("gate high with command low");
	a_loss_fast_off: assert property (
		!primary_supply_ok_i && primary_energy_ok_i |=> ##1 !gate_drive_out_o)
		else $error("gate still high after primary loss");
	a_ce_low_pins: assert property (
		!xfer_enable_i |=> !fault_indicator_n_oe_n_o && !alarm_indicator_n_oe_n_o)
		else $error("comparator pins not pulled with transfer disabled");
	a_fault_slot_value: assert property (
		tick && slot == SLOT_FAULT && live && xfer_enable_i && primary_supply_ok_i
		&& !fault_compare_in_i && !(latch_mode && fault_hold) |=> fault_indicator_n_oe_n_o)
		else $error("fault pin not released in its slot");
	a_fault_slot_trip: assert property (
		tick && slot == SLOT_FAULT && live && xfer_enable_i && primary_supply_ok_i
		&& (fault_compare_in_i || (latch_mode && fault_hold)) |=> !fault_indicator_n_oe_n_o)
		else $error("fault pin not pulled in its slot");
	a_fault_gate_low: assert property (
		fault_now |=> !gate_drive_out_o [*2])
		else $error("gate high right after fault");
	a_latch_wait: assert property (
		latch_mode && fault_hold && !en_low_seen && !fault_now |=> fault_hold)
		else $error("latched fault released without command toggle");
	a_slot_order: assert property (
		tick && slot == SLOT_FAULT |=> slot == SLOT_ALARM ##0 !tick [*8])
		else $error("back-channel order or spacing wrong");
	a_startup_quiet: assert property (
		!live |=> !fault_indicator_n_oe_n_o && !alarm_indicator_n_oe_n_o && !power_ok_indicator_o)
		else $error("indicator released during start-up");

	c_fault_recover: cover property (fault_hold ##1 !fault_hold);
	c_latch_release: cover property (latch_mode && fault_hold ##1 !fault_hold);
	c_power_live: cover property ($rose(power_ok_indicator_o));
	c_loss_timeout: cover property (!primary_supply_ok_i && !primary_energy_ok_i && $fell(prim_seen));
endmodule

// ### idm_host_model.sv
// Primary-side controller model: enable and command drive, indicator pull-ups
`timescale 1ns/1ps
module idm_host_model
(
	input  wire logic clk_i,
	input  wire logic enable_req_i,
	input  wire logic cmd_req_i,
	input  wire logic fault_oe_n_i,
	input  wire logic alarm_oe_n_i,
	input  wire logic power_oe_n_i,
	input  wire logic power_dat_i,
	output logic      xfer_enable_o,
	output logic      switch_cmd_o,
	output logic      fault_pin_o,
	output logic      alarm_pin_o,
	output logic      power_pin_o
);
	// Board pull-ups: a released open-drain pin reads high, never the last value
	assign fault_pin_o = fault_oe_n_i ? 1'h1 : 1'h0;
	assign alarm_pin_o = alarm_oe_n_i ? 1'h1 : 1'h0;
	assign power_pin_o = power_oe_n_i ? 1'h1 : power_dat_i;

	// Requests leave on a clock edge, as the controller's own logic would
	always_ff @(posedge clk_i)
	begin
		xfer_enable_o <= enable_req_i;
		switch_cmd_o  <= cmd_req_i;
	end
endmodule

// ### testbench.sv
// Self-checking testbench for the isolated driver mode control
`timescale 1ns/1ps
module testbench import idm_pkg::*;;
	localparam int ST = 200;
	localparam int RC = 10;
	localparam int PL = 5;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        prim, energy, rail_h, rail_m, en_req, cmd_req, fcmp, acmp;
	logic        gate, keep_off, pok, pok_oe_n, fn, fn_oe_n, an, an_oe_n;
	logic        xen, scmd, fpin, apin, ppin;
	int          error_cnt, n_compared, n;

	// Short counts keep the run brief
	idm_mode_ctrl #(.STARTUP_LEN(ST), .RECOVERY_LEN(RC), .PRIM_LOSS_LEN(PL)) dut
	(
		.clk_i(clk), .rst_n_i(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.primary_supply_ok_i(prim), .primary_energy_ok_i(energy),
		.secondary_high_rail_ok_i(rail_h), .secondary_mid_rail_ok_i(rail_m),
		.xfer_enable_i(xen), .switch_cmd_i(scmd), .fault_compare_in_i(fcmp),
		.alarm_compare_in_i(acmp), .gate_drive_out_o(gate), .keep_off_o(keep_off),
		.power_ok_indicator_o(pok), .power_ok_indicator_oe_n_o(pok_oe_n),
		.fault_indicator_n_o(fn), .fault_indicator_n_oe_n_o(fn_oe_n),
		.alarm_indicator_n_o(an), .alarm_indicator_n_oe_n_o(an_oe_n)
	);

	idm_host_model host
	(
		.clk_i(clk), .enable_req_i(en_req), .cmd_req_i(cmd_req), .fault_oe_n_i(fn_oe_n),
		.alarm_oe_n_i(an_oe_n), .power_oe_n_i(pok_oe_n), .power_dat_i(pok),
		.xfer_enable_o(xen), .switch_cmd_o(scmd), .fault_pin_o(fpin), .alarm_pin_o(apin),
		.power_pin_o(ppin)
	);

	// ----
	// Clock, reset and helpers
	// ----
	initial
	begin
		clk = 0;
		forever #4 clk = ~clk;
	end

	task automatic stop_test();
		$display("compared=%0d errors=%0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic pin(input int s);
		return s == 0 ? gate : s == 1 ? fpin : s == 2 ? apin : ppin;
	endfunction

	// Bounded wait on one observed level; n returns the cycles taken
	task automatic wait_for(input int s, input logic v, input int lim);
		n = 0;
		while (pin(s) !== v && n < lim)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({31'h0, pin(s)}, {31'h0, v});
		if (pin(s) !== v)
			stop_test();
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (k >= 50)
		begin
			chk(32'h0, 32'h1);
			stop_test();
		end
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		stop_test();
	end

	// ----
	// Stimulus
	// ----
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{prim, energy, rail_h, rail_m, fcmp, acmp} = '0;
		{en_req, cmd_req} = 2'h3;
		error_cnt = 0;
		n_compared = 0;
		rst_n = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1;
		cyc(3);
		chk({29'h0, gate, keep_off, pok_oe_n}, 32'h3);
		@(posedge clk);
		{prim, energy, rail_h, rail_m} <= 4'hf;
		wait_for(0, 1, 3);
		cyc(95);
		chk({29'h0, fpin, apin, ppin}, 32'h0);
		wait_for(3, 1, ST + 200);
		wait_for(1, 1, 200);
		wait_for(2, 1, 200);
		@(posedge clk);
		acmp <= 1;
		wait_for(2, 0, 160);
		chk({31'h0, gate}, 32'h1);
		@(posedge clk);
		acmp <= 0;
		wait_for(2, 1, 160);
		@(posedge clk);
		fcmp <= 1;
		cyc(2);
		chk({31'h0, gate}, 32'h0);
		wait_for(1, 0, 160);
		// Alarm raised just after the fault slot: its slot follows one spacing on
		@(posedge clk);
		acmp <= 1;
		wait_for(2, 0, 60);
		chk({31'h0, n > 45 && n <= SPACING_CYC}, 32'h1);
		@(posedge clk);
		{fcmp, acmp} <= 2'h0;
		wait_for(0, 1, RC + 10);
		chk({31'h0, n >= RC - 1}, 32'h1);
		apb(1, ADDR_CTRL, 32'h1);
		apb(0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h1);
		@(posedge clk);
		fcmp <= 1;
		cyc(3);
		@(posedge clk);
		fcmp <= 0;
		cyc(RC + 20);
		chk({31'h0, gate}, 32'h0);
		@(posedge clk);
		cmd_req <= 0;
		cyc(3);
		@(posedge clk);
		cmd_req <= 1;
		wait_for(0, 1, RC + 10);
		apb(1, ADDR_CTRL, 32'h0);
		wait_for(1, 1, 200);
		wait_for(2, 1, 200);
		apb(0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h3d);
		// Unmapped place: error flagged, nothing read
		apb(0, 8'h08, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		@(posedge clk);
		en_req <= 0;
		cyc(4);
		chk({26'h0, gate, fpin, apin, ppin, fn, an}, 32'h0);
		@(posedge clk);
		en_req <= 1;
		wait_for(3, 1, 200);
		@(posedge clk);
		prim <= 0;
		cyc(2);
		chk({30'h0, gate, ppin}, 32'h0);
		@(posedge clk);
		prim <= 1;
		wait_for(0, 1, 5);
		// Energy gone: drop only after the loss timeout
		@(posedge clk);
		{prim, energy} <= 2'h0;
		wait_for(0, 0, PL + 4);
		chk({31'h0, n >= PL - 1}, 32'h1);
		// Mid-run reset clears the latching selection and re-applies keep-off
		apb(1, ADDR_CTRL, 32'h1);
		@(posedge clk);
		rst_n <= 0;
		cyc(2);
		chk({28'h0, gate, keep_off, fn_oe_n, pok_oe_n}, 32'h5);
		@(posedge clk);
		rst_n <= 1;
		apb(0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h0);
		stop_test();
	end
endmodule
